// *** core/egs_divider.sv ***
// Two cascaded programmable dividers producing a one-cycle tick.
// Assumes the divisor fields use zero as one; tick rate is clk/(a*b).
`timescale 1ns/10ps
`default_nettype none
module egs_divider (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Settings and tick
  egs_tick_if.dvd t
);
  logic [7:0] cnt_a_reg;
  logic [7:0] cnt_b_reg;
  logic tick_reg;
  wire logic [7:0] lim_a = (t.div_a == 8'h00) ? 8'h00 : t.div_a - 8'h01;
  wire logic [7:0] lim_b = (t.div_b == 8'h00) ? 8'h00 : t.div_b - 8'h01;
  wire logic wrap_a = (cnt_a_reg >= lim_a);
  wire logic wrap_b = wrap_a && (cnt_b_reg >= lim_b);
  assign t.tick = tick_reg;
  always_ff @(posedge mclk) begin
    if (reset || !t.run) begin
      cnt_a_reg <= 8'h00;
      cnt_b_reg <= 8'h00;
      tick_reg <= 1'b0;
    end else begin
      cnt_a_reg <= wrap_a ? 8'h00 : cnt_a_reg + 8'h01;
      if (wrap_a) begin
        cnt_b_reg <= wrap_b ? 8'h00 : cnt_b_reg + 8'h01;
      end
      tick_reg <= wrap_b;
    end
  end
endmodule
`default_nettype wire

// *** core/egs_gpio.sv ***
// Overview of operation
// - Input status read returns pin levels with controller status bits.
// - Input status write stores nothing, raises event pulses instead.
// - Output register drives the general output pins.
// - Firmware events leave as one-cycle pulses for interrupt wiring.
// - Input modes: direct, 16-bit parallel, 28-bit shift; mode 3 reads as direct.
// - Output modes: direct drive or serial shift-out only.
// - Shift-out presents one data bit per strobe clock rising edge.
// - Shift rate is core clock over twice the product of two dividers.
// - Free-running strobe by default; fixed count emits programmed pulses.
// - Fixed packet up to 255 bits; completion sets done bit 17.
// - Two 16-bit shadow buffers loaded by output bits 29, 30.
// - Shift-in samples data pin each internal tick into 28 bits.
// - Shift-in fills bit 0 to 27, then discards extra samples.
// - Shift-in contents read as input status bits 0 to 27.
// - Shift-in sample clock also from two cascaded dividers.
// - After start bit, sixteen-sample flag pulses every 16 samples.
//
// Top of the enhanced GPIO block: register port, shift-out, shift-in.
// Assumes pins are synchronous to mclk and strobes are one cycle long.
`timescale 1ns/10ps
`default_nettype none
module egs_gpio
  import egs_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Pins
  input wire logic [29:0] general_input_pins,
  input wire logic serial_data_in_pin,
  output logic [31:0] general_output_pins,
  // Interrupt controller paths
  input wire logic [1:0] input_status_bits,
  output logic [31:0] system_events,
  output logic shift_done_event,
  output logic sixteen_sample_count_flag
);
  logic [31:0] out_reg;
  logic [31:0] cfg_reg;
  logic [31:0] div_reg;
  logic [15:0] par_reg;
  logic [15:0] shd0_reg;
  logic [15:0] shd1_reg;
  logic full0_reg;
  logic full1_reg;
  logic [15:0] act_reg;
  logic act_sel_reg;
  logic [3:0] bit_reg;
  logic [7:0] pulse_reg;
  logic strobe_reg;
  logic sdo_reg;
  egs_state_e state_reg;
  logic done_reg;
  logic [27:0] sin_reg;
  logic [4:0] fill_reg;
  logic started_reg;
  logic prev_reg;
  logic [3:0] grp_reg;
  logic cnt16_reg;
  logic [31:0] rdata_reg;
  logic [31:0] gpo_reg;
  logic [31:0] ev_reg;
  logic done_ev_reg;

  egs_tick_if tx_t ();
  egs_tick_if rx_t ();
  egs_divider u_tx_div (.mclk(mclk), .reset(reset), .t(tx_t));
  egs_divider u_rx_div (.mclk(mclk), .reset(reset), .t(rx_t));

  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    hit = (a == o);
  endfunction

  wire logic wr_out = reg_wr && hit(reg_addr, OFS_OUT);
  wire logic wr_in = reg_wr && hit(reg_addr, OFS_IN);
  wire logic wr_cfg = reg_wr && hit(reg_addr, OFS_CFG);
  wire logic wr_div = reg_wr && hit(reg_addr, OFS_DIV);
  wire logic wr_sh0 = reg_wr && hit(reg_addr, OFS_SHD0);
  wire logic wr_sh1 = reg_wr && hit(reg_addr, OFS_SHD1);
  wire logic [1:0] imode = cfg_reg[CFG_IMODE_LSB+:2];
  wire logic shift_out_mode = cfg_reg[CFG_OMODE_BIT];
  wire logic fixed_mode = cfg_reg[CFG_FIXED_BIT];
  wire logic [7:0] pkt_len = cfg_reg[CFG_LEN_LSB+:8];
  wire logic start_fixed = wr_cfg && reg_wdata[CFG_START_BIT];
  wire logic load0 = wr_out && reg_wdata[OUT_LOAD0_BIT];
  wire logic load1 = wr_out && reg_wdata[OUT_LOAD1_BIT];
  wire logic running = (state_reg == EGS_RUN);
  wire logic tx_tick = tx_t.tick;
  wire logic rx_tick = rx_t.tick;
  // One strobe period spans two ticks: rise then fall.
  wire logic rise = running && tx_tick && !strobe_reg;
  wire logic fall = running && tx_tick && strobe_reg;
  wire logic last_bit = (bit_reg == 4'hF);
  wire logic other_full = act_sel_reg ? full0_reg : full1_reg;
  wire logic pkt_end = fixed_mode && fall && (pulse_reg == 8'h01);
  wire logic shift_in_on = (imode == EGS_IN_SHIFT);
  wire logic sample = shift_in_on && rx_tick;
  wire logic start_seen = sample && !started_reg &&
    (serial_data_in_pin != prev_reg);
  wire logic group_end = sample && started_reg && (grp_reg == 4'hF);
  // shift-in bits read back at 27:0
  wire logic [29:0] status_low = shift_in_on ? {2'b00, sin_reg} :
    (imode == EGS_IN_PARALLEL) ? {14'h0000, par_reg} : general_input_pins;
  // read path mixes pins and controller status
  wire logic [31:0] in_word = {input_status_bits, status_low};
  wire logic [31:0] cfg_word = {cfg_reg[31:18], done_reg, cfg_reg[16:0]};
  wire logic [31:0] rd_mux =
    hit(reg_addr, OFS_OUT) ? out_reg :
    hit(reg_addr, OFS_IN) ? in_word :
    hit(reg_addr, OFS_CFG) ? cfg_word :
    hit(reg_addr, OFS_DIV) ? div_reg :
    hit(reg_addr, OFS_SHD0) ? {16'h0000, shd0_reg} :
    hit(reg_addr, OFS_SHD1) ? {16'h0000, shd1_reg} :
    hit(reg_addr, OFS_PAR) ? {16'h0000, par_reg} : ZERO_WORD;
  // direct drive or shift-out on pins 0 and 1
  wire logic [31:0] gpo_next = shift_out_mode ?
    {out_reg[31:2], strobe_reg, sdo_reg} : out_reg;

  assign tx_t.div_a = div_reg[7:0];
  assign tx_t.div_b = div_reg[15:8];
  assign tx_t.run = running;
  // shift-in uses its own cascaded divider pair
  assign rx_t.div_a = div_reg[23:16];
  assign rx_t.div_b = div_reg[31:24];
  assign rx_t.run = shift_in_on;
  assign reg_rdata = rdata_reg;
  assign general_output_pins = gpo_reg;
  assign system_events = ev_reg;
  assign shift_done_event = done_ev_reg;
  assign sixteen_sample_count_flag = cnt16_reg;

  always_ff @(posedge mclk) begin
    if (reset) begin
      out_reg <= ZERO_WORD;
      cfg_reg <= CFG_RESET;
      div_reg <= DIV_RESET;
      rdata_reg <= ZERO_WORD;
      gpo_reg <= ZERO_WORD;
      ev_reg <= ZERO_WORD;
      par_reg <= 16'h0000;
    end else begin
      if (wr_out) out_reg <= reg_wdata;
      if (wr_cfg) cfg_reg <= reg_wdata;
      if (wr_div) div_reg <= reg_wdata;
      rdata_reg <= reg_rd ? rd_mux : ZERO_WORD;
      gpo_reg <= gpo_next;
      // writes to input status only raise events
      ev_reg <= wr_in ? reg_wdata : ZERO_WORD;
      // parallel capture latches the low pins each cycle
      if (imode == EGS_IN_PARALLEL) par_reg <= general_input_pins[15:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      shd0_reg <= 16'h0000;
      shd1_reg <= 16'h0000;
    end else begin
      if (wr_sh0) shd0_reg <= reg_wdata[15:0];
      if (wr_sh1) shd1_reg <= reg_wdata[15:0];
    end
  end

  wire logic take_other = fall && last_bit && other_full;
  wire logic take0 = take_other && !act_sel_reg;
  wire logic take1 = take_other && act_sel_reg;
  always_ff @(posedge mclk) begin
    if (reset) begin
      full0_reg <= 1'b0;
      full1_reg <= 1'b0;
    end else begin
      // A fresh load wins over the buffer being taken.
      full0_reg <= load0 ? 1'b1 : (take0 ? 1'b0 : full0_reg);
      full1_reg <= load1 ? 1'b1 : (take1 ? 1'b0 : full1_reg);
    end
  end

  // free-running default, fixed mode counts pulses
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= EGS_IDLE;
      pulse_reg <= 8'h00;
    end else begin
      case (state_reg)
        EGS_IDLE: begin
          // The start pulse comes with the very write that sets the mode,
          // so it is judged on the write data, not on the old settings.
          if (start_fixed && reg_wdata[CFG_OMODE_BIT]) begin
            state_reg <= EGS_RUN;
            pulse_reg <= reg_wdata[CFG_LEN_LSB+:8];
          end else if (shift_out_mode && !fixed_mode) begin
            state_reg <= EGS_RUN;
            pulse_reg <= pkt_len;
          end
        end
        EGS_RUN: begin
          if (!shift_out_mode || pkt_end) begin
            state_reg <= EGS_IDLE;
          end else if (fixed_mode && fall) begin
            pulse_reg <= pulse_reg - 8'h01;
          end
        end
        default: state_reg <= EGS_IDLE;
      endcase
    end
  end

  // bit presented before each strobe rise, first bit of a run with the rise, MSB first
  // swap buffers on the last bit without a gap
  always_ff @(posedge mclk) begin
    if (reset || !running) begin
      strobe_reg <= 1'b0;
      sdo_reg <= 1'b0;
      bit_reg <= 4'h0;
      act_sel_reg <= 1'b0;
      act_reg <= 16'h0000;
    end else begin
      if (tx_tick) strobe_reg <= !strobe_reg;
      if (rise && bit_reg == 4'h0) begin
        sdo_reg <= act_reg[15];
      end
      if (fall) begin
        bit_reg <= bit_reg + 4'h1;
        if (last_bit) begin
          act_sel_reg <= other_full ? !act_sel_reg : act_sel_reg;
          act_reg <= !other_full ? act_reg :
            (act_sel_reg ? shd0_reg : shd1_reg);
          sdo_reg <= !other_full ? act_reg[15] :
            (act_sel_reg ? shd0_reg[15] : shd1_reg[15]);
        end else begin
          act_reg <= {act_reg[14:0], 1'b0};
          sdo_reg <= act_reg[14];
        end
      end
      if (bit_reg == 4'h0 && !strobe_reg && !tx_tick && full0_reg &&
          act_reg == 16'h0000) begin
        act_reg <= shd0_reg;
      end
    end
  end

  // done flag at bit 17 on packet end
  // held until cleared or restart; set wins over clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      done_reg <= 1'b0;
      done_ev_reg <= 1'b0;
    end else begin
      done_reg <= pkt_end ? 1'b1 :
        ((start_fixed || (wr_cfg && reg_wdata[CFG_DONE_CLR_BIT])) ? 1'b0 :
        done_reg);
      done_ev_reg <= pkt_end;
    end
  end

  // fill from bit 0 upward, extra samples dropped
  // first transition taken as start, not stored
  always_ff @(posedge mclk) begin
    if (reset || !shift_in_on) begin
      sin_reg <= 28'h0000000;
      fill_reg <= 5'h00;
      started_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else if (sample) begin
      prev_reg <= serial_data_in_pin;
      if (start_seen) begin
        started_reg <= 1'b1;
      end else if (started_reg && fill_reg < 5'(SHIFT_IN_W)) begin
        sin_reg[fill_reg] <= serial_data_in_pin;
        fill_reg <= fill_reg + 5'h01;
      end
    end
  end

  // flag pulses each 16 samples after start
  always_ff @(posedge mclk) begin
    if (reset || !shift_in_on) begin
      grp_reg <= 4'h0;
      cnt16_reg <= 1'b0;
    end else begin
      if (sample && started_reg) grp_reg <= grp_reg + 4'h1;
      cnt16_reg <= group_end;
    end
  end

  a_event_pulse: assert property (@(posedge mclk) disable iff (reset)
    wr_in |=> (ev_reg == $past(reg_wdata)) ##1 (ev_reg == 32'h0 || $past(wr_in)))
    else $error("event pulse wrong");
  a_read_late: assert property (@(posedge mclk) disable iff (reset)
    reg_rd && hit(reg_addr, OFS_IN) |=>
    reg_rdata[31:30] == $past(input_status_bits))
    else $error("read data wrong");
  a_done_set: assert property (@(posedge mclk) disable iff (reset)
    pkt_end |=> done_reg && done_ev_reg)
    else $error("done not set");
  a_done_hold: assert property (@(posedge mclk) disable iff (reset)
    done_reg && !wr_cfg |=> done_reg)
    else $error("done dropped");
  a_fill_cap: assert property (@(posedge mclk) disable iff (reset)
    fill_reg <= 5'h1C)
    else $error("fill overflow");
  a_cnt16_one: assert property (@(posedge mclk) disable iff (reset)
    cnt16_reg |=> !cnt16_reg)
    else $error("flag not self clear");
  a_gpo_direct: assert property (@(posedge mclk) disable iff (reset)
    !shift_out_mode && $stable(out_reg) |=> gpo_reg == $past(out_reg))
    else $error("pins not driven");
  a_strobe_idle: assert property (@(posedge mclk) disable iff (reset)
    !running |=> !strobe_reg)
    else $error("strobe active idle");
endmodule
`default_nettype wire

// *** core/egs_pkg.sv ***
// Package for the enhanced GPIO shift link: offsets, fields, reset values.
// Assumes a single 50 MHz clock domain shared by all users.
package egs_pkg;
  // Register indices on the plain register port.
  localparam logic [3:0] OFS_OUT = 4'h0;
  localparam logic [3:0] OFS_IN = 4'h1;
  localparam logic [3:0] OFS_CFG = 4'h2;
  localparam logic [3:0] OFS_DIV = 4'h3;
  localparam logic [3:0] OFS_SHD0 = 4'h4;
  localparam logic [3:0] OFS_SHD1 = 4'h5;
  localparam logic [3:0] OFS_PAR = 4'h6;
  // Output register fields.
  localparam int OUT_LOAD0_BIT = 29;
  localparam int OUT_LOAD1_BIT = 30;
  // Configuration register fields.
  localparam int CFG_IMODE_LSB = 0;
  localparam int CFG_OMODE_BIT = 2;
  localparam int CFG_FIXED_BIT = 3;
  localparam int CFG_START_BIT = 4;
  localparam int CFG_LEN_LSB = 8;
  localparam int CFG_DONE_BIT = 17;
  localparam int CFG_DONE_CLR_BIT = 18;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] DIV_RESET = 32'h0000_0101;
  localparam int SHIFT_IN_W = 28;
  localparam int SHADOW_W = 16;
  localparam int SAMPLE_GROUP = 16;
  localparam int MAX_PACKET = 255;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  typedef enum logic [1:0] {
    EGS_IN_DIRECT, EGS_IN_PARALLEL, EGS_IN_SHIFT, EGS_IN_ETH
  } egs_imode_e;
  typedef enum {EGS_IDLE, EGS_RUN} egs_state_e;
endpackage

// *** core/egs_tick_if.sv ***
// Interface carrying one cascaded divider's settings and its tick.
// Assumes the owner drives the divisors and the divider drives the tick.
`timescale 1ns/10ps
`default_nettype none
interface egs_tick_if;
  logic [7:0] div_a;
  logic [7:0] div_b;
  logic run;
  logic tick;
  modport ctl (output div_a, output div_b, output run, input tick);
  modport dvd (input div_a, input div_b, input run, output tick);
endinterface
`default_nettype wire

// *** tb/egs_shift_rx.sv ***
// Receiver model for the serial shift-out link of the GPIO block.
// Assumes strobe and data are registered outputs synchronous to mclk.
`timescale 1ns/10ps
`default_nettype none
module egs_shift_rx (
  // Clock and control
  input wire logic mclk,
  input wire logic clear,
  // Link pins
  input wire logic strobe,
  input wire logic data,
  // Collected results
  output logic [31:0] rx_word,
  output logic [8:0] rx_count,
  output logic [7:0] gap_min,
  output logic [7:0] gap_max
);
  logic strobe_reg;
  logic [7:0] gap_reg;
  // The gap counter saturates so that a stalled link cannot wrap it.
  always_ff @(posedge mclk) begin
    strobe_reg <= strobe;
    if (clear) begin
      rx_word <= 32'h0000_0000;
      rx_count <= 9'h000;
      gap_reg <= 8'h00;
      gap_min <= 8'hFF;
      gap_max <= 8'h00;
    end else begin
      if (gap_reg != 8'hFF) begin
        gap_reg <= gap_reg + 8'h01;
      end
      if (strobe && !strobe_reg) begin
        rx_word <= {rx_word[30:0], data};
        rx_count <= rx_count + 9'h001;
        gap_reg <= 8'h01;
        if (rx_count != 9'h000) begin
          gap_min <= (gap_reg < gap_min) ? gap_reg : gap_min;
          gap_max <= (gap_reg > gap_max) ? gap_reg : gap_max;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the enhanced GPIO shift link top.
// Assumes one 50 MHz clock and the register map of the package.
`timescale 1ns/10ps
`default_nettype none
module testbench import egs_pkg::*;;
  logic mclk, reset, reg_wr, reg_rd, serial_data_in_pin, rx_clear;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, general_output_pins, system_events;
  logic [29:0] general_input_pins;
  logic [1:0] input_status_bits;
  logic shift_done_event, sixteen_sample_count_flag;
  logic [31:0] rx_word, d;
  logic [8:0] rx_count;
  logic [7:0] gap_min, gap_max;
  logic [29:0] pat;
  int err_count, tests_run, cnt0;
  int sixteen_total = 0;
  egs_gpio u_dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .general_input_pins(general_input_pins),
    .serial_data_in_pin(serial_data_in_pin),
    .general_output_pins(general_output_pins),
    .input_status_bits(input_status_bits), .system_events(system_events),
    .shift_done_event(shift_done_event),
    .sixteen_sample_count_flag(sixteen_sample_count_flag));
  egs_shift_rx u_rx (.mclk(mclk), .clear(rx_clear),
    .strobe(general_output_pins[1]), .data(general_output_pins[0]),
    .rx_word(rx_word), .rx_count(rx_count), .gap_min(gap_min),
    .gap_max(gap_max));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (sixteen_sample_count_flag === 1'b1) sixteen_total <= sixteen_total + 1;
  end
  task summarize;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task check32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task check1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task reg_write(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task reg_read(input logic [3:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task clear_rx;
    @(posedge mclk);
    rx_clear <= 1'b1;
    @(posedge mclk);
    rx_clear <= 1'b0;
  endtask
  task wait_done(input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge mclk);
      #1;
      if (shift_done_event === 1'b1) return;
    end
    err_count++;
    $display("MISMATCH t=%0t packet end not seen", $time);
    summarize;
  endtask
  initial begin
    reset = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0;
    reg_wdata = 32'h0; serial_data_in_pin = 1'b0; rx_clear = 1'b1;
    general_input_pins = 30'h1234_5678; input_status_bits = 2'h2;
    err_count = 0; tests_run = 0;
    pat = 30'h2B5C_3E17;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    rx_clear <= 1'b0;
    reg_read(OFS_CFG, d); check32(d, CFG_RESET);
    reg_read(OFS_DIV, d); check32(d, DIV_RESET);
    reg_write(OFS_CFG, 32'h0000_0003);
    reg_read(OFS_IN, d); check32(d, {2'h2, 30'h1234_5678});
    reg_write(OFS_CFG, 32'h0000_0001);
    reg_read(OFS_IN, d); check32(d, {2'h2, 14'h0, 16'h5678});
    reg_read(OFS_PAR, d); check32(d, 32'h0000_5678);
    reg_write(OFS_CFG, ZERO_WORD);
    reg_read(OFS_IN, d); check32(d, {2'h2, 30'h1234_5678});
    reg_write(OFS_IN, 32'hA5C3_0F01);
    #1 check32(system_events, 32'hA5C3_0F01);
    @(posedge mclk);
    #1 check32(system_events, ZERO_WORD);
    reg_read(OFS_IN, d); check32(d, {2'h2, 30'h1234_5678});
    reg_write(OFS_OUT, 32'h1234_5678);
    @(posedge mclk);
    #1 check32(general_output_pins, 32'h1234_5678);
    reg_write(4'hF, 32'hFFFF_FFFF);
    #1 check32(general_output_pins, 32'h1234_5678);
    reg_read(4'h7, d); check32(d, ZERO_WORD);
    // A 32-pulse packet spans both shadow buffers back to back.
    reg_write(OFS_DIV, 32'h0000_0101);
    reg_write(OFS_SHD0, 32'h0000_8000);
    reg_write(OFS_SHD1, 32'h0000_00A5);
    reg_write(OFS_OUT, 32'h6000_0000);
    clear_rx;
    reg_write(OFS_CFG, 32'h0000_201C);
    wait_done(200);
    repeat (4) @(posedge mclk);
    check32(rx_word, 32'h8000_00A5);
    check32({23'h0, rx_count}, 32'd32);
    check32({16'h0, gap_min, gap_max}, 32'h0000_0202);
    reg_read(OFS_CFG, d); check1(d[CFG_DONE_BIT], 1'b1);
    repeat (20) @(posedge mclk);
    reg_read(OFS_CFG, d); check1(d[CFG_DONE_BIT], 1'b1);
    reg_write(OFS_CFG, 32'h0004_0000);
    reg_read(OFS_CFG, d); check1(d[CFG_DONE_BIT], 1'b0);
    reg_write(OFS_DIV, 32'h0000_0302);
    reg_write(OFS_SHD0, 32'h0000_8000);
    reg_write(OFS_OUT, 32'h2000_0000);
    clear_rx;
    reg_write(OFS_CFG, 32'h0000_081C);
    wait_done(300);
    repeat (16) @(posedge mclk);
    check32({23'h0, rx_count}, 32'd8);
    check32({24'h0, rx_word[7:0]}, 32'h0000_0080);
    check32({16'h0, gap_min, gap_max}, 32'h0000_0C0C);
    reg_write(OFS_DIV, 32'h0000_0101);
    clear_rx;
    reg_write(OFS_CFG, 32'h0000_0004);
    repeat (40) @(posedge mclk);
    check1(rx_count >= 9'd18 && rx_count <= 9'd21, 1'b1);
    reg_write(OFS_CFG, ZERO_WORD);
    reg_write(OFS_OUT, 32'h0000_0003);
    @(posedge mclk);
    #1 check32(general_output_pins, 32'h0000_0003);
    // Idle line is low, so the first high sample is the start bit.
    reg_write(OFS_CFG, 32'h0000_0002);
    repeat (3) @(posedge mclk);
    serial_data_in_pin <= 1'b1;
    cnt0 = sixteen_total;
    for (int i = 0; i < 30; i++) begin
      @(posedge mclk);
      serial_data_in_pin <= pat[i];
      if (i == 24) check32(sixteen_total - cnt0, 32'd1);
    end
    repeat (2) @(posedge mclk);
    reg_read(OFS_IN, d);
    check32({d[31:30], 2'h0, d[27:0]}, {2'h2, 2'h0, pat[27:0]});
    summarize;
  end
endmodule
`default_nettype wire
